// >>> rtl/mrps_sequencer.sv
// mrps_sequencer: power-up, normal shutdown, fast fault shutdown and auto restart
// of the supplies and the three mirror rails (offset, bias, reset).
// assumes asynchronous pins for request, over-temperature and undervoltage, and a
// same-clock register master with one-cycle strobes.
//
// Function
// - request high starts power-up to running
// - request low shuts everything down to off
// - supplies first, then mirror rails one by one
// - offset first, bias after programmed wait
// - reset rail after second programmed wait
// - normal: bias/reset stop, 10 ms, offset
// - reset low, 1 ms, discharge, supplies off
// - fault output stays high in a request-driven normal shutdown
// - fault asserts output, starts fast shutdown
// - fast shutdown control bit, on from reset
// - fast: bias/reset stop after programmed delay
// - second delay, then discharge and reset low
// - finally drop the mirror rails enable
// - stay in standby while fault persists
// - fault gone: third supply, then normal startup
// - undervoltage starts the rail shutdown
// - automatic steps run in this state machine
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module mrps_sequencer #(
   parameter int TICK_CYCLES = mrps_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // pins from outside
   input wire logic projector_on_request,
   input wire logic over_temp,
   input wire logic main_input_supply_low,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   // supplies and rails
   output logic [3:0] supply_enable,
   output logic mirror_offset_rail,
   output logic mirror_bias_rail,
   output logic mirror_reset_rail,
   output logic rail_discharge,
   output logic mirror_rails_enable,
   // system signals
   output logic system_reset_n,
   output logic fault_int_n
);
   // refuse a time base that the 16-bit divider cannot count
   if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
   begin
      $error("mrps_sequencer: TICK_CYCLES must lie in 1..65535");
   end

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

   typedef struct packed {
      mrps_pkg::mrps_state_t st;
      logic [15:0] div;
      logic tick;
      logic [15:0] cnt;
      logic [2:0] pon_s;
      logic [2:0] ot_s;
      logic [2:0] uv_s;
      logic pon;
      logic ot;
      logic uv;
      logic fast_en;
      logic [7:0] f2s_code;
      logic [7:0] s2d_code;
      logic [15:0] ofs_wait;
      logic [15:0] bias_wait;
      logic fault;
      logic [15:0] rdata;
      logic [3:0] supply;
      logic ofs;
      logic bias;
      logic rst_rail;
      logic disch;
      logic rails_en;
      logic sys_rst_n;
      logic int_n;
   } mrps_regs_t;

   mrps_regs_t r_q;
   mrps_regs_t r_d;

   // a pin change counts only once the last two stages agree
   function automatic logic mrps_filt(input logic [2:0] s, input logic cur);
      mrps_filt = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   logic fault_now;
   logic step_done;

   always_comb
   begin
      r_d = r_q;
      fault_now = r_q.ot | r_q.uv;
      step_done = r_q.tick && (r_q.cnt == 16'h0000);

      // pin synchronisers; stage 0 feeds only stage 1
      r_d.pon_s = {r_q.pon_s[1:0], projector_on_request};
      r_d.ot_s = {r_q.ot_s[1:0], over_temp};
      r_d.uv_s = {r_q.uv_s[1:0], main_input_supply_low};
      r_d.pon = mrps_filt(r_q.pon_s, r_q.pon);
      r_d.ot = mrps_filt(r_q.ot_s, r_q.ot);
      r_d.uv = mrps_filt(r_q.uv_s, r_q.uv);

      // time base: one tick pulse every TICK_CYCLES clocks
      r_d.tick = 1'b0;
      if (r_q.div == TICK_LAST)
      begin
         r_d.div = 16'h0000;
         r_d.tick = 1'b1;
      end
      else
      begin
         r_d.div = r_q.div + 16'h0001;
      end
      if (r_q.tick && r_q.cnt != 16'h0000)
         r_d.cnt = r_q.cnt - 16'h0001;

      // register writes
      if (reg_write)
      begin
         case (reg_addr)
            mrps_pkg::ADDR_CTRL:
               r_d.fast_en = reg_wdata[mrps_pkg::CTRL_FAST_EN_BIT];
            mrps_pkg::ADDR_FAULT_DELAY:
            begin
               r_d.f2s_code = reg_wdata[mrps_pkg::FDLY_F2S_LSB +: 8];
               r_d.s2d_code = reg_wdata[mrps_pkg::FDLY_S2D_LSB +: 8];
            end
            mrps_pkg::ADDR_OFS_WAIT:
               r_d.ofs_wait = reg_wdata;
            mrps_pkg::ADDR_BIAS_WAIT:
               r_d.bias_wait = reg_wdata;
            default:
               r_d.fast_en = r_q.fast_en;
         endcase
      end

      // register reads; unmapped offsets answer zero
      r_d.rdata = 16'h0000;
      if (reg_read)
      begin
         case (reg_addr)
            mrps_pkg::ADDR_CTRL:
               r_d.rdata[mrps_pkg::CTRL_FAST_EN_BIT] = r_q.fast_en;
            mrps_pkg::ADDR_FAULT_DELAY:
               r_d.rdata = {r_q.f2s_code, r_q.s2d_code};
            mrps_pkg::ADDR_OFS_WAIT:
               r_d.rdata = r_q.ofs_wait;
            mrps_pkg::ADDR_BIAS_WAIT:
               r_d.rdata = r_q.bias_wait;
            mrps_pkg::ADDR_STATUS:
            begin
               r_d.rdata[mrps_pkg::STAT_STATE_LSB +: 4] = r_q.st;
               r_d.rdata[mrps_pkg::STAT_PON_BIT] = r_q.pon;
               r_d.rdata[mrps_pkg::STAT_OT_BIT] = r_q.ot;
               r_d.rdata[mrps_pkg::STAT_UV_BIT] = r_q.uv;
               r_d.rdata[mrps_pkg::STAT_FAULT_BIT] = r_q.fault;
            end
            default:
               r_d.rdata = 16'h0000;
         endcase
      end

      // fault latch: a new fault always wins over its clear in standby
      if (fault_now)
         r_d.fault = 1'b1;
      r_d.int_n = ~(r_q.fault | fault_now);

      // sequence; every step is taken here without software help
      case (r_q.st)
         mrps_pkg::ST_OFF:
         begin
            // nothing is powered here, so a fault that has gone leaves no latch behind
            if (!fault_now)
               r_d.fault = 1'b0;
            if (r_q.pon && !fault_now)
            begin
               r_d.st = mrps_pkg::ST_SUPPLY_UP;
               r_d.supply = mrps_pkg::SUPPLY_ALL;
               r_d.cnt = mrps_pkg::SUPPLY_SETTLE_TICKS;
            end
         end
         mrps_pkg::ST_THIRD_UP:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_SUPPLY_UP;
               r_d.supply = mrps_pkg::SUPPLY_ALL;
               r_d.cnt = mrps_pkg::SUPPLY_SETTLE_TICKS;
            end
         end
         mrps_pkg::ST_SUPPLY_UP:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_OFFSET_ON;
               r_d.ofs = 1'b1;
               r_d.rails_en = 1'b1;
               r_d.cnt = r_q.ofs_wait;
            end
         end
         mrps_pkg::ST_OFFSET_ON:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_BIAS_ON;
               r_d.bias = 1'b1;
               r_d.cnt = r_q.bias_wait;
            end
         end
         mrps_pkg::ST_BIAS_ON:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_RUN;
               r_d.rst_rail = 1'b1;
               r_d.sys_rst_n = 1'b1;
            end
         end
         mrps_pkg::ST_RUN:
            r_d.st = mrps_pkg::ST_RUN;
         mrps_pkg::ST_NS_RAILS_STOP:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_NS_RESET_LOW;
               r_d.ofs = 1'b0;
               r_d.sys_rst_n = 1'b0;
               r_d.cnt = mrps_pkg::NORM_RESET_GAP_TICKS;
            end
         end
         mrps_pkg::ST_NS_RESET_LOW:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_NS_DISCHARGE;
               r_d.disch = 1'b1;
               r_d.cnt = mrps_pkg::DISCHARGE_TICKS;
            end
         end
         mrps_pkg::ST_NS_DISCHARGE:
         begin
            if (step_done)
            begin
               r_d.disch = 1'b0;
               r_d.rails_en = 1'b0;
               r_d.supply = mrps_pkg::SUPPLY_NONE;
               r_d.st = r_q.fault ? mrps_pkg::ST_STANDBY : mrps_pkg::ST_OFF;
            end
         end
         mrps_pkg::ST_FS_WAIT_STOP:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_FS_WAIT_DISCH;
               r_d.bias = 1'b0;
               r_d.rst_rail = 1'b0;
               r_d.cnt = {8'h00, r_q.s2d_code};
            end
         end
         mrps_pkg::ST_FS_WAIT_DISCH:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_FS_FINAL;
               r_d.ofs = 1'b0;
               r_d.disch = 1'b1;
               r_d.sys_rst_n = 1'b0;
               r_d.cnt = mrps_pkg::DISCHARGE_TICKS;
            end
         end
         mrps_pkg::ST_FS_FINAL:
         begin
            if (step_done)
            begin
               r_d.st = mrps_pkg::ST_STANDBY;
               r_d.rails_en = 1'b0;
               r_d.disch = 1'b0;
               r_d.supply = mrps_pkg::SUPPLY_NONE;
            end
         end
         mrps_pkg::ST_STANDBY:
         begin
            if (!fault_now)
            begin
               r_d.fault = 1'b0;
               r_d.st = mrps_pkg::ST_THIRD_UP;
               r_d.supply[mrps_pkg::THIRD_SUPPLY_BIT] = 1'b1;
               r_d.cnt = mrps_pkg::SUPPLY_SETTLE_TICKS;
            end
         end
         default:
            r_d.st = mrps_pkg::ST_OFF;
      endcase

      // shutdown entry from the start-up states and run, not from shutdown or standby; a fault outranks the request
      if (r_q.st inside {mrps_pkg::ST_SUPPLY_UP, mrps_pkg::ST_OFFSET_ON,
                         mrps_pkg::ST_BIAS_ON, mrps_pkg::ST_RUN,
                         mrps_pkg::ST_THIRD_UP})
      begin
         if (fault_now && r_q.fast_en)
         begin
            r_d.st = mrps_pkg::ST_FS_WAIT_STOP;
            r_d.cnt = {8'h00, r_q.f2s_code};
         end
         else if (fault_now || !r_q.pon)
         begin
            r_d.st = mrps_pkg::ST_NS_RAILS_STOP;
            r_d.bias = 1'b0;
            r_d.rst_rail = 1'b0;
            r_d.cnt = mrps_pkg::NORM_RAIL_GAP_TICKS;
         end
      end
   end

   // one register for the whole state; reset gives constants only
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         r_q <= '0;
         r_q.st <= mrps_pkg::ST_OFF;
         r_q.fast_en <= mrps_pkg::RST_FAST_EN;
         r_q.f2s_code <= mrps_pkg::RST_F2S_CODE;
         r_q.s2d_code <= mrps_pkg::RST_S2D_CODE;
         r_q.ofs_wait <= mrps_pkg::RST_OFS_WAIT;
         r_q.bias_wait <= mrps_pkg::RST_BIAS_WAIT;
         r_q.int_n <= 1'b1;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = r_q.rdata;
   assign supply_enable = r_q.supply;
   assign mirror_offset_rail = r_q.ofs;
   assign mirror_bias_rail = r_q.bias;
   assign mirror_reset_rail = r_q.rst_rail;
   assign rail_discharge = r_q.disch;
   assign mirror_rails_enable = r_q.rails_en;
   assign system_reset_n = r_q.sys_rst_n;
   assign fault_int_n = r_q.int_n;
endmodule

// >>> rtl/mrps_pkg.sv
// mrps_pkg: constants, register map and state type of the mirror rail power sequencer.
// assumes a 100 MHz mclk and a plain 8-bit address / 16-bit data register port.
package mrps_pkg;
   // clock and time base
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 4;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   // fixed waits, in microseconds, and as time-base ticks
   localparam int NORM_RAIL_GAP_US = 10000;
   localparam int NORM_RESET_GAP_US = 1000;
   localparam int SUPPLY_SETTLE_US = 1000;
   localparam int DISCHARGE_US = 1000;
   localparam logic [15:0] NORM_RAIL_GAP_TICKS = 16'((NORM_RAIL_GAP_US + TICK_US - 1) / TICK_US - 1);
   localparam logic [15:0] NORM_RESET_GAP_TICKS = 16'((NORM_RESET_GAP_US + TICK_US - 1) / TICK_US - 1);
   localparam logic [15:0] SUPPLY_SETTLE_TICKS = 16'((SUPPLY_SETTLE_US + TICK_US - 1) / TICK_US - 1);
   localparam logic [15:0] DISCHARGE_TICKS = 16'((DISCHARGE_US + TICK_US - 1) / TICK_US - 1);
   localparam logic [15:0] FINAL_STEP_TICKS = 16'h0000;
   // register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h01;
   localparam logic [7:0] ADDR_FAULT_DELAY = 8'h0F;
   localparam logic [7:0] ADDR_OFS_WAIT = 8'h10;
   localparam logic [7:0] ADDR_BIAS_WAIT = 8'h11;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   // field positions
   localparam int CTRL_FAST_EN_BIT = 0;
   localparam int FDLY_F2S_LSB = 8;
   localparam int FDLY_S2D_LSB = 0;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_PON_BIT = 4;
   localparam int STAT_OT_BIT = 5;
   localparam int STAT_UV_BIT = 6;
   localparam int STAT_FAULT_BIT = 7;
   // reset values; delay codes count ticks minus one
   localparam logic RST_FAST_EN = 1'b1;
   localparam logic [7:0] RST_F2S_CODE = 8'h86;
   localparam logic [7:0] RST_S2D_CODE = 8'h00;
   localparam logic [15:0] RST_OFS_WAIT = 16'h00F9;
   localparam logic [15:0] RST_BIAS_WAIT = 16'h00F9;
   // supply enable bit of the third supply output
   localparam int THIRD_SUPPLY_BIT = 2;
   localparam logic [3:0] SUPPLY_ALL = 4'hF;
   localparam logic [3:0] SUPPLY_NONE = 4'h0;

   typedef enum logic [3:0] {
      ST_OFF,
      ST_THIRD_UP,
      ST_SUPPLY_UP,
      ST_OFFSET_ON,
      ST_BIAS_ON,
      ST_RUN,
      ST_NS_RAILS_STOP,
      ST_NS_RESET_LOW,
      ST_NS_DISCHARGE,
      ST_FS_WAIT_STOP,
      ST_FS_WAIT_DISCH,
      ST_FS_FINAL,
      ST_STANDBY
   } mrps_state_t;
endpackage

// >>> verification/mrps_sequencer_assertions.sv
// mrps_sequencer_assertions: port-level checks of rail order and fault reporting.
// assumes it is bound into mrps_sequencer and shares its mclk and sync reset.
`timescale 1ns/1ps
module mrps_sequencer_assertions (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // pins and register port
   input wire logic projector_on_request,
   input wire logic over_temp,
   input wire logic main_input_supply_low,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   // supplies, rails and system signals
   input wire logic [3:0] supply_enable,
   input wire logic mirror_offset_rail,
   input wire logic mirror_bias_rail,
   input wire logic mirror_reset_rail,
   input wire logic rail_discharge,
   input wire logic mirror_rails_enable,
   input wire logic system_reset_n,
   input wire logic fault_int_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // steps of a fault-free shutdown
   sequence s_normal_stop;
      $fell(mirror_bias_rail) && fault_int_n;
   endsequence
   sequence s_offset_drop;
      $fell(mirror_offset_rail) && fault_int_n;
   endsequence
   // a bias rail without offset would overstress the array
   a_bias_needs_offset: assert property (mirror_bias_rail |-> mirror_offset_rail)
      else $error("bias rail up without offset rail");
   a_reset_needs_bias: assert property (mirror_reset_rail |-> mirror_bias_rail)
      else $error("reset rail up without bias rail");
   a_rails_need_supply: assert property (mirror_offset_rail |-> supply_enable == 4'hF)
      else $error("offset rail up before all supplies");
   // both shutdown paths drop bias and reset rails while system reset is still released
   a_sysreset_in_run: assert property (system_reset_n |-> mirror_offset_rail)
      else $error("system reset released without offset rail");
   a_sysreset_release: assert property ($rose(system_reset_n) |->
      mirror_offset_rail && mirror_bias_rail && mirror_reset_rail)
      else $error("system reset released before all rails");
   a_discharge_reset_low: assert property ($rose(rail_discharge) |-> !system_reset_n)
      else $error("discharge started with system reset released");
   a_no_discharge_live: assert property (rail_discharge |->
      !mirror_offset_rail && !mirror_bias_rail && !mirror_reset_rail)
      else $error("discharge while a rail regulates");
   // eight cycles cover the pin filter plus the output register
   a_fault_int_temp: assert property (over_temp [*8] |-> !fault_int_n)
      else $error("over temperature not reported");
   a_fault_int_uv: assert property (main_input_supply_low [*8] |-> !fault_int_n)
      else $error("undervoltage not reported");
   a_enable_after_disch: assert property ($fell(mirror_rails_enable) |->
      $past(rail_discharge) && !mirror_offset_rail)
      else $error("rails enable dropped before discharge");
   a_normal_offset_hold: assert property (s_normal_stop |=> mirror_offset_rail [*8])
      else $error("offset rail dropped early in normal shutdown");
   a_normal_disch_wait: assert property (s_offset_drop |-> !rail_discharge [*8])
      else $error("discharge too soon after offset stop");
endmodule

bind mrps_sequencer mrps_sequencer_assertions i_chk (.mclk(mclk), .reset(reset),
   .projector_on_request(projector_on_request), .over_temp(over_temp),
   .main_input_supply_low(main_input_supply_low), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .supply_enable(supply_enable),
   .mirror_offset_rail(mirror_offset_rail), .mirror_bias_rail(mirror_bias_rail),
   .mirror_reset_rail(mirror_reset_rail), .rail_discharge(rail_discharge),
   .mirror_rails_enable(mirror_rails_enable), .system_reset_n(system_reset_n),
   .fault_int_n(fault_int_n));

// >>> verification/mrps_far_side.sv
// mrps_far_side: system controller and mirror array as seen from the rails.
// assumes the bench commands the power state through host_on.
`timescale 1ns/1ps
module mrps_far_side (
   // clock
   input wire logic mclk,
   // command from the bench
   input wire logic host_on,
   // rails and reset from the sequencer
   input wire logic mirror_offset_rail,
   input wire logic mirror_bias_rail,
   input wire logic mirror_reset_rail,
   input wire logic system_reset_n,
   // towards the sequencer and the bench
   output logic projector_on_request,
   output logic array_ready
);
   initial projector_on_request = 1'b0;
   // only the power request is host driven; rail steps are left to the sequencer
   always @(posedge mclk)
   begin
      projector_on_request <= host_on;
   end
   // images only with every rail up and reset released
   assign array_ready = system_reset_n && mirror_offset_rail && mirror_bias_rail
      && mirror_reset_rail;
endmodule

// >>> verification/mrps_sequencer_tb.sv
// mrps_sequencer_tb: register table, power-up, normal and fast shutdown, restart.
// assumes a shortened time base of four clocks a tick.
`timescale 1ns/1ps
module mrps_sequencer_tb;
   typedef struct {logic wr; logic [7:0] addr; logic [15:0] data;} mrps_row_t;
   logic mclk = 1'b0, reset = 1'b1, host_on = 1'b0, over_temp = 1'b0, uv_low = 1'b0;
   logic reg_write = 1'b0, reg_read = 1'b0, req, rst_rail, disch, rails_en, sys_n, int_n;
   logic offs, bias, ready;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
   logic [3:0] supply;
   wire logic [7:0] watch = {|supply, int_n, sys_n, rails_en, disch, rst_rail, bias, offs};
   int fail_count = 0, total_checks = 0, low_cnt = 0, n, snap;
   mrps_row_t rows [14] = '{
      '{0, 8'h01, 16'h0001}, '{0, 8'h0F, 16'h8600},
      '{0, 8'h10, 16'h00F9}, '{0, 8'h11, 16'h00F9},
      '{0, 8'h33, 16'h0000}, '{0, 8'h20, 16'h0000},
      '{1, 8'h10, 16'h0002}, '{0, 8'h10, 16'h0002},
      '{1, 8'h11, 16'h0003}, '{0, 8'h11, 16'h0003},
      '{1, 8'h0F, 16'h0201}, '{0, 8'h0F, 16'h0201},
      '{1, 8'h20, 16'hFFFF}, '{0, 8'h20, 16'h0000}};
   always #5 mclk = ~mclk;
   // counts cycles of reported fault, so a quiet shutdown can be proven
   always @(posedge mclk)
      if (int_n === 1'b0)
         low_cnt++;
   mrps_sequencer #(.TICK_CYCLES(4)) i_dut (.mclk(mclk), .reset(reset),
      .projector_on_request(req), .over_temp(over_temp), .main_input_supply_low(uv_low),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .supply_enable(supply),
      .mirror_offset_rail(offs), .mirror_bias_rail(bias), .mirror_reset_rail(rst_rail),
      .rail_discharge(disch), .mirror_rails_enable(rails_en), .system_reset_n(sys_n),
      .fault_int_n(int_n));
   mrps_far_side i_far (.mclk(mclk), .host_on(host_on), .mirror_offset_rail(offs),
      .mirror_bias_rail(bias), .mirror_reset_rail(rst_rail), .system_reset_n(sys_n),
      .projector_on_request(req), .array_ready(ready));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // phase of the time base and the sampling point give a few cycles of slack
   task automatic near(input int got, input int exp);
      total_checks++;
      if (got < exp - 6 || got > exp + 6)
      begin
         fail_count++;
         $display("unexpected at %0t: %0d cycles, want %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
      @(posedge mclk);
   endtask
   // waits on one watched output, sampled mid-cycle, and returns aligned to an edge
   task automatic wait_bit(input int b, input logic v, output int cyc);
      cyc = 0;
      do
      begin
         @(negedge mclk);
         cyc++;
      end
      while (watch[b] !== v && cyc < 20000);
      if (cyc >= 20000)
         check(16'h0000, 16'h0001);
      @(posedge mclk);
   endtask
   task automatic power_up;
      host_on <= 1'b1;
      wait_bit(0, 1'b1, n);
      check(16'(supply), 16'h000F);
      check(16'(bias), 16'h0000);
      wait_bit(1, 1'b1, n);
      near(n, 12);
      wait_bit(2, 1'b1, n);
      near(n, 16);
      check(16'(sys_n), 16'h0001);
      check(16'(ready), 16'h0001);
   endtask
   task automatic done(input string name);
      $display("test %s done", name);
   endtask
   initial
   begin
      repeat (80000) @(posedge mclk);
      fail_count++;
      stop_test;
   end
   initial
   begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      foreach (rows[i])
         if (rows[i].wr)
            wr(rows[i].addr, rows[i].data);
         else
         begin
            rd(rows[i].addr, d);
            check(d, rows[i].data);
         end
      done("registers");
      power_up;
      rd(8'h20, d);
      check(d, 16'h0015);
      done("power up");
      snap = low_cnt;
      host_on <= 1'b0;
      wait_bit(1, 1'b0, n);
      wait_bit(0, 1'b0, n);
      near(n, 10000);
      check(16'(sys_n), 16'h0000);
      wait_bit(3, 1'b1, n);
      near(n, 1000);
      wait_bit(3, 1'b0, n);
      check(16'(supply), 16'h0000);
      check(16'(low_cnt - snap), 16'h0000);
      done("normal shutdown");
      power_up;
      over_temp <= 1'b1;
      wait_bit(6, 1'b0, n);
      near(n, 5);
      wait_bit(1, 1'b0, n);
      near(n, 12);
      wait_bit(0, 1'b0, n);
      near(n, 8);
      check(16'({disch, sys_n}), 16'h0002);
      wait_bit(4, 1'b0, n);
      near(n, 1000);
      repeat (2000) @(posedge mclk);
      check(16'(supply), 16'h0000);
      rd(8'h20, d);
      check(d, 16'h00BC);
      over_temp <= 1'b0;
      wait_bit(7, 1'b1, n);
      check(16'(supply), 16'h0004);
      power_up;
      done("fast shutdown and restart");
      uv_low <= 1'b1;
      wait_bit(6, 1'b0, n);
      wait_bit(1, 1'b0, n);
      near(n, 12);
      uv_low <= 1'b0;
      wait_bit(7, 1'b0, n);
      near(n, 1008);
      power_up;
      done("undervoltage");
      wr(8'h01, 16'h0000);
      over_temp <= 1'b1;
      wait_bit(6, 1'b0, n);
      wait_bit(1, 1'b0, n);
      near(n, 1);
      wait_bit(0, 1'b0, n);
      near(n, 10000);
      over_temp <= 1'b0;
      reset <= 1'b1;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      check(16'({supply, int_n}), 16'h0001);
      rd(8'h01, d);
      check(d, 16'h0001);
      done("fast shutdown off and reset");
      stop_test;
   end
endmodule
